// file: rtl/buckboost_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Trigger bit starts move to held code
// - Trigger self-clears when reference reaches target
// - Trigger reads one while move in progress
// - Discharge path on while trigger set
// - Target frozen while trigger is zero
// - Good-delay bit delays power-good rise 100us
// - Limit code bits 6:0, resets 60
// - Pin low: off; pin high: bit 7
// - Enable bit off keeps register contents
// - Bit 6 selects retry or latch-off
// - Bit 5 enables output discharge at pin shutdown
// - Bit 4 forces pulse-width at light load
// - Frequency field resets 00, others reserved
// - Droop field bits 7:6, resets 00
// - Droop only at settings of 5V up
// - Soft-start field bits 5:4, resets 11
// - Status bit 7 live power good
// - Status bits 6,5 thermal shutdown, warning
// - Status bit 4 constant-current mode
// - Output code 11 bits, low three, high eight
// - Output slews one millivolt per microsecond
module buckboost_regs
  import buckboost_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h69,
  parameter int PG_DELAY = PG_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_pin,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire buckboost_pkg::condition_in_t condition_in,
  output logic [10:0] vref_code,
  output logic power_good,
  output buckboost_pkg::regulator_ctl_t regulator_ctl
);
  import buckboost_pkg::*;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_REG,
    BUS_WDATA,
    BUS_RDATA
  } bus_state_t;

  bus_state_t state_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  logic [7:0] ptr_ff;
  logic sda_out_ff;
  logic sda_oe_ff;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] read_byte;

  logic [2:0] vout_low_ff;
  logic [7:0] vout_high_ff;
  logic go_ff;
  logic good_delay_enable_ff;
  logic [6:0] current_limit_code_ff;
  logic [5:0] converter_control_one_ff;
  logic [3:0] converter_control_two_ff;
  logic enable_prev_ff;
  logic bank_reload;
  logic go_start;
  logic ramp_done;
  logic [10:0] vref;
  logic good_delayed;
  regulator_ctl_t nxt_ctl;
  regulator_ctl_t ctl_ff;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl && !scl_prev_ff;
  assign scl_fall = !scl && scl_prev_ff;
  assign bus_start = scl && scl_prev_ff && sda_prev_ff && !sda_in;
  assign bus_stop = scl && scl_prev_ff && !sda_prev_ff && sda_in;

  // Serial interface is held off while the enable pin is low
  assign bank_reload = sys_rst || (enable_pin && !enable_prev_ff);
  assign wr_en = (state_ff == BUS_WDATA) && scl_fall && (bitcnt_ff == BIT_ACK);
  assign wr_data = shift_ff;

  function automatic logic [7:0] read_mux(input logic [7:0] ofs);
    logic [7:0] val;
    val = '0;
    unique case (ofs)
      OFS_VOUT_LOW: val = {5'h00, vout_low_ff};
      OFS_VOUT_HIGH: val = vout_high_ff;
      OFS_VOLTAGE_UPDATE: val = {6'h00, good_delay_enable_ff, go_ff};
      OFS_CURRENT_LIMIT: val = {1'b0, current_limit_code_ff};
      OFS_CONTROL_ONE: val = {converter_control_one_ff, 2'b00};
      OFS_CONTROL_TWO: val = {converter_control_two_ff, 4'h0};
      // Live values, nothing latched
      OFS_CONDITION: val = {good_delayed, condition_in.thermal_shutdown,
                            condition_in.thermal_warning_flag,
                            condition_in.regulation_mode_flag, 4'h0};
      default: val = '0;
    endcase
    return val;
  endfunction

  // Byte loaded for the next read slot; a process so bank changes are seen
  always_comb begin
    read_byte = read_mux(ptr_ff);
  end

  // Write strobe aimed at one register of the bank
  function automatic logic reg_write(input logic [7:0] ofs);
    return wr_en && (ptr_ff == ofs);
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl;
      sda_prev_ff <= sda_in;
    end
  end

  // Pin history for the reload edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_prev_ff <= 1'b0;
    end else begin
      enable_prev_ff <= enable_pin;
    end
  end

  // Serial byte engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge clk) begin
    if (sys_rst || !enable_pin) begin
      state_ff <= BUS_IDLE;
      bitcnt_ff <= '0;
      shift_ff <= '0;
      rw_ff <= 1'b0;
      ptr_ff <= '0;
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff <= BUS_ADDR;
      bitcnt_ff <= '0;
      sda_oe_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff <= BUS_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (state_ff != BUS_IDLE) begin
      if (scl_rise) begin
        if (bitcnt_ff < BIT_ACK) begin
          if (state_ff != BUS_RDATA) begin
            shift_ff <= {shift_ff[6:0], sda_in};
          end
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end else if (bitcnt_ff == BIT_ACK) begin
          // Master not acknowledging ends a read
          if (state_ff == BUS_RDATA && sda_in) begin
            state_ff <= BUS_IDLE;
          end else begin
            bitcnt_ff <= BIT_AFTER_ACK;
          end
        end
      end else if (scl_fall) begin
        if (bitcnt_ff == BIT_ACK) begin
          unique case (state_ff)
            BUS_ADDR: begin
              if (shift_ff[7:1] == DEVICE_ADDR) begin
                rw_ff <= shift_ff[0];
                sda_oe_ff <= 1'b1;
              end else begin
                state_ff <= BUS_IDLE;
              end
            end
            BUS_REG: begin
              ptr_ff <= shift_ff;
              sda_oe_ff <= 1'b1;
            end
            BUS_WDATA: begin
              ptr_ff <= ptr_ff + 8'h01;
              sda_oe_ff <= 1'b1;
            end
            BUS_RDATA: sda_oe_ff <= 1'b0;
            default: sda_oe_ff <= 1'b0;
          endcase
        end else if (bitcnt_ff == BIT_AFTER_ACK) begin
          bitcnt_ff <= '0;
          if ((state_ff == BUS_ADDR && rw_ff) || state_ff == BUS_RDATA) begin
            state_ff <= BUS_RDATA;
            shift_ff <= read_byte;
            ptr_ff <= ptr_ff + 8'h01;
            // Open drain: pull low for a zero only
            sda_oe_ff <= !read_byte[7];
          end else begin
            state_ff <= (state_ff == BUS_ADDR) ? BUS_REG : BUS_WDATA;
            sda_oe_ff <= 1'b0;
          end
        end else if (state_ff == BUS_RDATA) begin
          sda_oe_ff <= !shift_ff[3'(7 - 32'(bitcnt_ff))];
        end
      end
    end
  end

  // Output code registers
  always_ff @(posedge clk) begin
    if (bank_reload) begin
      vout_low_ff <= VOUT_RESET[VOUT_LOW_BITS-1:0];
    end else if (reg_write(OFS_VOUT_LOW)) begin
      vout_low_ff <= wr_data[VOUT_LOW_BITS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_reload) begin
      vout_high_ff <= VOUT_RESET[10:VOUT_LOW_BITS];
    end else if (reg_write(OFS_VOUT_HIGH)) begin
      vout_high_ff <= wr_data;
    end
  end

  // Only a one written to the trigger starts a move; codes alone do nothing
  assign go_start = wr_en && ptr_ff == OFS_VOLTAGE_UPDATE && wr_data[GO_BIT];

  always_ff @(posedge clk) begin
    if (bank_reload) begin
      go_ff <= 1'b0;
    end else if (go_start) begin
      // A fresh start in the done cycle keeps the bit set
      go_ff <= 1'b1;
    end else if (ramp_done) begin
      go_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (bank_reload) begin
      good_delay_enable_ff <= 1'b0;
    end else if (reg_write(OFS_VOLTAGE_UPDATE)) begin
      good_delay_enable_ff <= wr_data[GOOD_DELAY_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_reload) begin
      current_limit_code_ff <= LIMIT_RESET;
    end else if (reg_write(OFS_CURRENT_LIMIT)) begin
      current_limit_code_ff <= wr_data[LIMIT_MSB:0];
    end
  end

  // Clearing the enable bit touches no other register
  always_ff @(posedge clk) begin
    if (bank_reload) begin
      converter_control_one_ff <= CONVERTER_CONTROL_ONE_RESET;
    end else if (reg_write(OFS_CONTROL_ONE)) begin
      converter_control_one_ff <= wr_data[7:CONVERTER_CONTROL_ONE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (bank_reload) begin
      converter_control_two_ff <= CONVERTER_CONTROL_TWO_RESET;
    end else if (reg_write(OFS_CONTROL_TWO)) begin
      converter_control_two_ff <= wr_data[7:CONVERTER_CONTROL_TWO_LSB];
    end
  end

  vref_ramp u_ramp (
    .clk(clk),
    .sys_rst(bank_reload),
    .start(go_start),
    .target({vout_high_ff, vout_low_ff}),
    .vref_ff(vref),
    .done_ff(ramp_done)
  );

  good_delay #(
    .DELAY_CYCLES(PG_DELAY)
  ) u_good (
    .clk(clk),
    .sys_rst(sys_rst),
    .good_raw(condition_in.power_good_raw),
    .delay_enable(good_delay_enable_ff),
    .good_ff(good_delayed)
  );

  always_comb begin
    nxt_ctl.converter_on = enable_pin && converter_control_one_ff[5];
    nxt_ctl.fault_retry_select = converter_control_one_ff[4];
    // Pin shutdown discharge uses the bank kept through the low period
    nxt_ctl.discharge_on = go_ff || (!enable_pin && converter_control_one_ff[3]);
    nxt_ctl.forced_pwm = converter_control_one_ff[2];
    nxt_ctl.switching_rate_select = converter_control_one_ff[1:0];
    nxt_ctl.droop_code = (vref >= DROOP_MIN_CODE) ? converter_control_two_ff[3:2] : 2'b00;
    nxt_ctl.soft_start_select = converter_control_two_ff[1:0];
    nxt_ctl.current_limit_code = current_limit_code_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_ff <= '0;
      vref_code <= VOUT_RESET;
      power_good <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      vref_code <= vref;
      power_good <= good_delayed;
    end
  end

  assign regulator_ctl = ctl_ff;
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;

endmodule
`default_nettype wire

// file: rtl/buckboost_pkg.sv
package buckboost_pkg;

  // Register offsets as seen on the serial bus
  localparam logic [7:0] OFS_VOUT_LOW = 8'h00;
  localparam logic [7:0] OFS_VOUT_HIGH = 8'h01;
  localparam logic [7:0] OFS_VOLTAGE_UPDATE = 8'h02;
  localparam logic [7:0] OFS_CURRENT_LIMIT = 8'h03;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h05;
  localparam logic [7:0] OFS_CONDITION = 8'h09;

  // Field positions
  localparam int VOUT_LOW_BITS = 3;
  localparam int GO_BIT = 0;
  localparam int GOOD_DELAY_BIT = 1;
  localparam int LIMIT_MSB = 6;
  localparam int CONVERTER_CONTROL_ONE_LSB = 2;
  localparam int CONVERTER_CONTROL_TWO_LSB = 4;
  localparam int COND_LSB = 4;

  // Reset values
  localparam logic [10:0] VOUT_RESET = 11'h1f4;
  localparam logic [6:0] LIMIT_RESET = 7'h3c;
  localparam logic [5:0] CONVERTER_CONTROL_ONE_RESET = 6'h3c;
  localparam logic [3:0] CONVERTER_CONTROL_TWO_RESET = 4'h3;

  // Droop only applies from 5 V setting upward (10 mV per code)
  localparam logic [10:0] DROOP_MIN_CODE = 11'h1f4;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int VOUT_LSB_MV = 10;
  localparam int SLEW_MV_PER_US = 1;
  localparam int STEP_TIME_NS = VOUT_LSB_MV * 1000 / SLEW_MV_PER_US;
  localparam int STEP_CYCLES = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PG_DELAY_US = 100;
  localparam int PG_DELAY_CYCLES = (PG_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Serial bus bit phases
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_AFTER_ACK = 4'h9;

  typedef struct packed {
    logic converter_on;
    logic fault_retry_select;
    logic discharge_on;
    logic forced_pwm;
    logic [1:0] switching_rate_select;
    logic [1:0] droop_code;
    logic [1:0] soft_start_select;
    logic [6:0] current_limit_code;
  } regulator_ctl_t;

  typedef struct packed {
    logic power_good_raw;
    logic thermal_shutdown;
    logic thermal_warning_flag;
    logic regulation_mode_flag;
  } condition_in_t;

endpackage

// file: rtl/vref_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module vref_ramp
  import buckboost_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [10:0] target,
  output logic [10:0] vref_ff,
  output logic done_ff
);
  logic [10:0] goal_ff;
  logic active_ff;
  logic [11:0] tick_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      goal_ff <= VOUT_RESET;
      active_ff <= 1'b0;
      tick_ff <= '0;
      vref_ff <= VOUT_RESET;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        goal_ff <= target;
        active_ff <= 1'b1;
        tick_ff <= '0;
      end else if (active_ff) begin
        if (vref_ff == goal_ff) begin
          active_ff <= 1'b0;
          done_ff <= 1'b1;
        end else if (tick_ff == 12'(STEP_CYCLES - 1)) begin
          // One code per step time gives the fixed slew
          tick_ff <= '0;
          vref_ff <= (goal_ff > vref_ff) ? vref_ff + 11'h001 : vref_ff - 11'h001;
        end else begin
          tick_ff <= tick_ff + 12'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/good_delay.sv
`timescale 1ns/1ps
`default_nettype none
module good_delay #(
  parameter int DELAY_CYCLES = 25000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic good_raw,
  input wire logic delay_enable,
  output logic good_ff
);
  logic [15:0] count_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= '0;
      good_ff <= 1'b0;
    end else if (!good_raw) begin
      // Falling edge is never delayed
      count_ff <= '0;
      good_ff <= 1'b0;
    end else if (!delay_enable || count_ff == 16'(DELAY_CYCLES - 1)) begin
      good_ff <= 1'b1;
    end else if (!good_ff) begin
      count_ff <= count_ff + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: verif/buckboost_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module buckboost_regs_properties
  import buckboost_pkg::*;
#(
  parameter int PG_DELAY = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_pin,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire buckboost_pkg::condition_in_t condition_in,
  input wire logic [10:0] vref_code,
  input wire logic power_good,
  input wire buckboost_pkg::regulator_ctl_t regulator_ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ramp_pause;
    $stable(vref_code)[*8];
  endsequence
  sequence s_step;
    vref_code == $past(vref_code) + 11'h001 || vref_code == $past(vref_code) - 11'h001;
  endsequence
  chk_pin_off: assert property (!enable_pin |=> !regulator_ctl.converter_on)
    else $error("converter on with pin low");
  chk_sda_quiet: assert property (!enable_pin |=> !sda_oe)
    else $error("bus driven with pin low");
  chk_droop_floor: assert property (regulator_ctl.droop_code != 2'b00 |->
    vref_code >= DROOP_MIN_CODE || $past(vref_code) >= DROOP_MIN_CODE)
    else $error("droop below floor");
  chk_pg_fall: assert property (!condition_in.power_good_raw |-> ##[1:2] !power_good)
    else $error("power good stuck high");
  chk_pg_cause: assert property ($rose(power_good) |-> $past(condition_in.power_good_raw, 2))
    else $error("power good without cause");
  chk_vref_step: assert property ($changed(vref_code) && $past(enable_pin, 3) |-> s_step)
    else $error("reference jumped");
  chk_vref_pace: assert property ($changed(vref_code) |=> s_ramp_pause)
    else $error("reference too fast");
  chk_vref_cause: assert property ($changed(vref_code) && $past(enable_pin, 3) |->
    regulator_ctl.discharge_on || $past(regulator_ctl.discharge_on))
    else $error("reference moved without trigger");
  chk_ctl_reset: assert property ($fell(sys_rst) && enable_pin |=>
    regulator_ctl.current_limit_code == LIMIT_RESET && regulator_ctl.forced_pwm
    && regulator_ctl.soft_start_select == 2'b11 && regulator_ctl.droop_code == 2'b00)
    else $error("control defaults wrong");
endmodule
bind buckboost_regs buckboost_regs_properties #(.PG_DELAY(PG_DELAY)) u_props (.clk(clk),
  .sys_rst(sys_rst), .enable_pin(enable_pin), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .condition_in(condition_in), .vref_code(vref_code),
  .power_good(power_good), .regulator_ctl(regulator_ctl));
`default_nettype wire

// file: verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic pull_low = 1'b0;
  logic ok;
  logic [6:0] addr = 7'h69;
  // Open drain with pull-up
  assign sda = ~(pull_low | sda_oe);
  initial scl = 1'b1;
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // Data moves one clock after scl falls, never beside it
  task automatic clock_bit(input logic b, output logic s);
    @(negedge clk);
    pull_low = ~b;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    pull_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk);
    pull_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b0;
    half();
  endtask
  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    if (s) ok = 1'b0;
  endtask
  // One value per frame, so callers can step the limit gently
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    ok = 1'b1;
    start();
    send_byte({addr, 1'b0});
    send_byte(ofs);
    send_byte(d);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic s;
    ok = 1'b1;
    start();
    send_byte({addr, 1'b0});
    send_byte(ofs);
    start();
    send_byte({addr, 1'b1});
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
    clock_bit(1'b1, s);
    stop();
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import buckboost_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] ofs;
    logic [7:0] wd;
    logic [3:0] cond;
    logic [7:0] exp;
  } row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_pin = 1'b1;
  condition_in_t condition_in = '0;
  wire scl;
  wire sda;
  logic sda_oe;
  logic sda_out;
  logic [10:0] vref_code;
  logic power_good;
  regulator_ctl_t regulator_ctl;
  int n_errors = 0;
  int comparisons = 0;
  int cnt;
  logic [7:0] rd;
  row_t rows[14] = '{
    '{1'b0, 8'h03, 8'h00, 4'h0, 8'h3c},
    '{1'b0, 8'h04, 8'h00, 4'h0, 8'hf0},
    '{1'b0, 8'h05, 8'h00, 4'h0, 8'h30},
    '{1'b0, 8'h02, 8'h00, 4'h0, 8'h00},
    '{1'b0, 8'h00, 8'h00, 4'h0, 8'h04},
    '{1'b0, 8'h01, 8'h00, 4'h0, 8'h3e},
    '{1'b1, 8'h03, 8'hd0, 4'h0, 8'h50},
    '{1'b1, 8'h05, 8'hff, 4'h0, 8'hf0},
    '{1'b1, 8'h09, 8'hff, 4'h7, 8'h70},
    '{1'b0, 8'h09, 8'h00, 4'h8, 8'h80},
    '{1'b0, 8'h07, 8'h00, 4'h0, 8'h00},
    '{1'b1, 8'h04, 8'hb3, 4'h0, 8'hb0},
    '{1'b1, 8'h04, 8'h43, 4'h0, 8'h40},
    '{1'b0, 8'h03, 8'h00, 4'h0, 8'h50}};
  always #2 clk = ~clk;
  buckboost_regs #(.PG_DELAY(20)) DUT (.clk(clk), .sys_rst(sys_rst), .enable_pin(enable_pin),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .condition_in(condition_in),
    .vref_code(vref_code), .power_good(power_good), .regulator_ctl(regulator_ctl));
  i2c_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic expire(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      condition_in = rows[i].cond;
      if (rows[i].wr) host.write_reg(rows[i].ofs, rows[i].wd);
      host.read_reg(rows[i].ofs, rd);
      check(rd, rows[i].exp, "readback");
    end
    check({regulator_ctl.fault_retry_select, regulator_ctl.forced_pwm}, 2'b10, "converter_control_one");
    check(regulator_ctl.switching_rate_select, 2'b00, "rate out");
    check({regulator_ctl.droop_code, regulator_ctl.soft_start_select}, 4'hf, "converter_control_two");
    check(regulator_ctl.current_limit_code, 7'h50, "limit out");
    $display("register table done");
    condition_in = '0;
    host.write_reg(8'h04, 8'hf0);
    host.write_reg(8'h00, 8'h03);
    repeat (20) @(negedge clk);
    check(vref_code, 11'h1f4, "target held");
    check(regulator_ctl.converter_on, 1'b1, "back on");
    host.write_reg(8'h02, 8'h01);
    host.read_reg(8'h02, rd);
    check(rd[0], 1'b1, "trigger busy");
    check(sda_out, 1'b0, "open drain level");
    check(regulator_ctl.discharge_on, 1'b1, "ramp discharge");
    cnt = 0;
    while (vref_code !== 11'h1f3 && cnt < 4000) begin
      @(negedge clk);
      cnt++;
    end
    expire(cnt, 4000);
    check(cnt > 1500 && cnt < 2600, 1'b1, "slew pace");
    check(regulator_ctl.droop_code, 2'b00, "droop floor");
    cnt = 0;
    while (rd[0] !== 1'b0 && cnt < 10) begin
      host.read_reg(8'h02, rd);
      cnt++;
    end
    expire(cnt, 10);
    check(rd[0], 1'b0, "trigger cleared");
    check(regulator_ctl.discharge_on, 1'b0, "discharge off");
    $display("ramp done");
    host.write_reg(8'h02, 8'h02);
    repeat (4) @(negedge clk);
    condition_in.power_good_raw = 1'b1;
    cnt = 0;
    while (power_good !== 1'b1 && cnt < 100) begin
      @(negedge clk);
      cnt++;
    end
    expire(cnt, 100);
    check(cnt >= 20 && cnt <= 23, 1'b1, "good delay");
    $display("good delay done");
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    check(regulator_ctl.converter_on, 1'b0, "pin off");
    check(regulator_ctl.discharge_on, 1'b1, "pin discharge");
    host.write_reg(8'h03, 8'h10);
    check(host.ok, 1'b0, "bus off");
    enable_pin = 1'b1;
    repeat (4) @(negedge clk);
    host.addr = 7'h6b;
    host.write_reg(8'h03, 8'h10);
    check(host.ok, 1'b0, "foreign address");
    host.addr = 7'h69;
    host.read_reg(8'h03, rd);
    check(rd, 8'h3c, "pin reload");
    $display("enable pin done");
    print_verdict();
  end
endmodule
`default_nettype wire
